// *** shared/lsc_pkg.sv ***
// Package: offsets, field positions and reset values for link/slot regs
// Assumes a 32-bit configuration dword access port with byte enables
package lsc_pkg;
  localparam logic [11:0] OFF_LINK_DWORD = 12'h00d0;
  localparam logic [11:0] OFF_SLOT_CAPS  = 12'h00d4;
  // Link dword: control low half, status high half
  localparam int RETRAIN_BIT    = 5;
  localparam int TRAIN_ERR_BIT  = 26;
  localparam int TRAINING_BIT   = 27;
  localparam int SLOT_CLK_BIT   = 28;
  localparam int DL_ACTIVE_BIT  = 29;
  // Slot capabilities fields
  localparam int PRESENCE_LSB   = 0;
  localparam int PRESENCE_W     = 5;
  localparam int SURPRISE_BIT   = 5;
  localparam int HP_CAP_BIT     = 6;
  localparam int PWR_VAL_LSB    = 7;
  localparam int PWR_VAL_W      = 8;
  localparam int PWR_SCL_LSB    = 15;
  localparam int PWR_SCL_W      = 2;
  localparam int SLOT_NUM_LSB   = 19;
  localparam int SLOT_NUM_W     = 13;
  // Reset values
  localparam logic [4:0]  RST_PRESENCE = 5'h1f;
  localparam logic        RST_SURPRISE = 1'b0;
  localparam logic        RST_HP_CAP   = 1'b1;
  localparam logic [7:0]  RST_PWR_VAL  = 8'h19;
  localparam logic [1:0]  RST_PWR_SCL  = 2'h0;
  localparam logic [12:0] RST_SLOT_NUM = 13'h0000;
  localparam logic        RST_SLOT_CLK = 1'b1;
  localparam logic        RST_TRAINING = 1'b1;
endpackage

// *** shared/lsc_dflt_if.sv ***
// Interface: default values carried between loader and register bank
// Assumes both ends on the core clock
`timescale 1ns/100ps
`default_nettype none
interface lsc_dflt_if;
  logic [4:0]  presence;
  logic        surprise;
  logic        hp_cap;
  logic [7:0]  pwr_val;
  logic [1:0]  pwr_scl;
  logic [12:0] slot_num;
  logic        slot_clk;
  logic        load;
  modport src (output presence, surprise, hp_cap, pwr_val, pwr_scl,
               slot_num, slot_clk, load);
  modport dst (input presence, surprise, hp_cap, pwr_val, pwr_scl,
               slot_num, slot_clk, load);
endinterface
`default_nettype wire

// *** src/lsc_dflt_load.sv ***
// Default loader: latches sideband/EEPROM overrides on a load strobe
// Assumes strobe and data come from core-clock sideband logic
`timescale 1ns/100ps
`default_nettype none
module lsc_dflt_load
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        ovr_load,
  input  wire logic [31:0] ovr_caps,
  input  wire logic        ovr_slot_clk,
  lsc_dflt_if.src          dflt
);
  logic [31:0] caps_reg;
  logic        clk_reg;
  logic        load_reg;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      caps_reg <= {lsc_pkg::RST_SLOT_NUM, 2'h0, lsc_pkg::RST_PWR_SCL,
                   lsc_pkg::RST_PWR_VAL, lsc_pkg::RST_HP_CAP,
                   lsc_pkg::RST_SURPRISE, lsc_pkg::RST_PRESENCE};
      clk_reg  <= lsc_pkg::RST_SLOT_CLK;
      load_reg <= 1'b0;
    end
    else
    begin
      load_reg <= ovr_load;
      if (ovr_load)
      begin
        caps_reg <= ovr_caps;
        clk_reg  <= ovr_slot_clk;
      end
    end
  end

  assign dflt.presence = caps_reg[lsc_pkg::PRESENCE_LSB +: lsc_pkg::PRESENCE_W];
  assign dflt.surprise = caps_reg[lsc_pkg::SURPRISE_BIT];
  assign dflt.hp_cap   = caps_reg[lsc_pkg::HP_CAP_BIT];
  assign dflt.pwr_val  = caps_reg[lsc_pkg::PWR_VAL_LSB +: lsc_pkg::PWR_VAL_W];
  assign dflt.pwr_scl  = caps_reg[lsc_pkg::PWR_SCL_LSB +: lsc_pkg::PWR_SCL_W];
  assign dflt.slot_num = caps_reg[lsc_pkg::SLOT_NUM_LSB +: lsc_pkg::SLOT_NUM_W];
  assign dflt.slot_clk = clk_reg;
  assign dflt.load     = load_reg;
endmodule
`default_nettype wire

// *** src/lsc_regs.sv ***
// Link status and slot capability registers of one switch port
// Assumes a single-cycle config access port and link-layer status inputs
//
// Functional notes
// - Training error sets on error, clears on successful L0 training.
// - Training-in-progress bit high during training, resets to one.
// - Slot clock bit reports connector reference clock use, resets one.
// - Data-link-active bit mirrors DL_Active state, resets zero.
// - Five presence flags in slot capability low bits, reset one.
// - Surprise-removal flag read-only, resets zero.
// - Hot-plug capable flag read-only, resets one.
// - Power limit value resets 19h; writes send power-limit message.
// - Power limit scale resets 00b; writes send power-limit message.
// - Thirteen-bit physical slot number, read-only, resets zero.
// - Capability and slot clock defaults replaceable by sideband load.
// - Slot capabilities exist only on downstream ports.
// - Retrain bit starts retraining on downstream ports, reads zero.
`timescale 1ns/100ps
`default_nettype none
module lsc_regs
#(
  parameter bit DOWNSTREAM = 1'b1
)
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [11:0] cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  input  wire logic        train_err_evt,
  input  wire logic        train_done_evt,
  input  wire logic        dl_active,
  input  wire logic        ovr_load,
  input  wire logic [31:0] ovr_caps,
  input  wire logic        ovr_slot_clk,
  output logic             retrain_req,
  output logic             spl_msg_req,
  output logic      [7:0]  spl_value,
  output logic      [1:0]  spl_scale
);
  lsc_dflt_if dflt ();

  lsc_dflt_load u_load
  (
    .clock        (clock),
    .rst_n        (rst_n),
    .ovr_load     (ovr_load),
    .ovr_caps     (ovr_caps),
    .ovr_slot_clk (ovr_slot_clk),
    .dflt         (dflt)
  );

  logic        train_err_reg;
  logic        training_reg;
  logic        dl_active_reg;
  logic        slot_clk_reg;
  logic [4:0]  presence_reg;
  logic        surprise_reg;
  logic        hp_cap_reg;
  logic [7:0]  pwr_val_reg;
  logic [1:0]  pwr_scl_reg;
  logic [12:0] slot_num_reg;
  logic        retrain_reg;
  logic        spl_reg;
  logic [31:0] rdata_reg;

  // Address decode
  wire hit_link = (cfg_addr == lsc_pkg::OFF_LINK_DWORD);
  wire hit_caps = (cfg_addr == lsc_pkg::OFF_SLOT_CAPS) && DOWNSTREAM;
  wire wr_caps  = cfg_wr && hit_caps;
  wire retrain_wr = cfg_wr && hit_link && cfg_be[0] && DOWNSTREAM &&
                    cfg_wdata[lsc_pkg::RETRAIN_BIT];
  wire wr_val_lo = wr_caps && cfg_be[0];
  wire wr_val_hi = wr_caps && cfg_be[1];
  wire wr_scl_lo = wr_caps && cfg_be[1];
  wire wr_scl_hi = wr_caps && cfg_be[2];
  wire spl_fire  = wr_val_lo || wr_val_hi || wr_scl_lo || wr_scl_hi;

  logic [7:0] pwr_val_next;
  logic [1:0] pwr_scl_next;
  assign pwr_val_next = {wr_val_hi ? cfg_wdata[14:8] : pwr_val_reg[7:1],
                         wr_val_lo ? cfg_wdata[7] : pwr_val_reg[0]};
  assign pwr_scl_next = {wr_scl_hi ? cfg_wdata[16] : pwr_scl_reg[1],
                         wr_scl_lo ? cfg_wdata[15] : pwr_scl_reg[0]};

  // Read image, reserved and retrain read zero
  logic [31:0] link_img;
  logic [31:0] caps_img;
  always_comb
  begin
    link_img = 32'h0000_0000;
    link_img[lsc_pkg::TRAIN_ERR_BIT] = train_err_reg;
    link_img[lsc_pkg::TRAINING_BIT]  = training_reg;
    link_img[lsc_pkg::SLOT_CLK_BIT]  = slot_clk_reg;
    link_img[lsc_pkg::DL_ACTIVE_BIT] = dl_active_reg;
    caps_img = 32'h0000_0000;
    caps_img[lsc_pkg::PRESENCE_LSB +: lsc_pkg::PRESENCE_W] = presence_reg;
    caps_img[lsc_pkg::SURPRISE_BIT] = surprise_reg;
    caps_img[lsc_pkg::HP_CAP_BIT]   = hp_cap_reg;
    caps_img[lsc_pkg::PWR_VAL_LSB +: lsc_pkg::PWR_VAL_W] = pwr_val_reg;
    caps_img[lsc_pkg::PWR_SCL_LSB +: lsc_pkg::PWR_SCL_W] = pwr_scl_reg;
    caps_img[lsc_pkg::SLOT_NUM_LSB +: lsc_pkg::SLOT_NUM_W] = slot_num_reg;
  end
  wire [31:0] rdata_next = hit_link ? link_img :
                           hit_caps ? caps_img : 32'h0000_0000;

  // Link status tracking
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      train_err_reg <= 1'b0;
      training_reg  <= lsc_pkg::RST_TRAINING;
      dl_active_reg <= 1'b0;
      retrain_reg   <= 1'b0;
    end
    else
    begin
      if (train_err_evt)
        train_err_reg <= 1'b1;
      else if (train_done_evt)
        train_err_reg <= 1'b0;
      if (retrain_wr)
        training_reg <= 1'b1;
      else if (train_done_evt)
        training_reg <= 1'b0;
      dl_active_reg <= dl_active;
      retrain_reg   <= retrain_wr;
    end
  end

  // Slot capability storage
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      presence_reg <= lsc_pkg::RST_PRESENCE;
      surprise_reg <= lsc_pkg::RST_SURPRISE;
      hp_cap_reg   <= lsc_pkg::RST_HP_CAP;
      pwr_val_reg  <= lsc_pkg::RST_PWR_VAL;
      pwr_scl_reg  <= lsc_pkg::RST_PWR_SCL;
      slot_num_reg <= lsc_pkg::RST_SLOT_NUM;
      slot_clk_reg <= lsc_pkg::RST_SLOT_CLK;
      spl_reg      <= 1'b0;
    end
    else if (dflt.load)
    begin
      presence_reg <= dflt.presence;
      surprise_reg <= dflt.surprise;
      hp_cap_reg   <= dflt.hp_cap;
      pwr_val_reg  <= dflt.pwr_val;
      pwr_scl_reg  <= dflt.pwr_scl;
      slot_num_reg <= dflt.slot_num;
      slot_clk_reg <= dflt.slot_clk;
      spl_reg      <= 1'b0;
    end
    else
    begin
      pwr_val_reg <= pwr_val_next;
      pwr_scl_reg <= pwr_scl_next;
      spl_reg     <= spl_fire;
    end
  end

  // Read data register
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rdata_reg <= 32'h0000_0000;
    else if (cfg_rd)
      rdata_reg <= rdata_next;
  end

  assign cfg_rdata   = rdata_reg;
  assign retrain_req = retrain_reg;
  assign spl_msg_req = spl_reg && DOWNSTREAM;
  assign spl_value   = pwr_val_reg;
  assign spl_scale   = pwr_scl_reg;
endmodule
`default_nettype wire

// *** sim/lsc_link_partner.sv ***
// Link partner model: counts power-limit messages, keeps last payload
// Assumes one-cycle message strobes on the core clock
`timescale 1ns/100ps
`default_nettype none
module lsc_link_partner
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       msg_req,
  input  wire logic [7:0] msg_value,
  input  wire logic [1:0] msg_scale,
  output logic      [7:0] msg_count_reg,
  output logic      [9:0] payload_reg
);
  // Capture each message as it arrives
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      msg_count_reg <= 8'h00;
      payload_reg   <= 10'h000;
    end
    else if (msg_req)
    begin
      msg_count_reg <= msg_count_reg + 8'h01;
      payload_reg   <= {msg_scale, msg_value};
    end
endmodule
`default_nettype wire

// *** sim/lsc_regs_chk.sv ***
// Checker: port assertions for the link/slot register block
// Assumes a downstream-port instance on one core clock
`timescale 1ns/100ps
`default_nettype none
module lsc_regs_chk
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        cfg_wr,
  input wire logic        cfg_rd,
  input wire logic [11:0] cfg_addr,
  input wire logic [3:0]  cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic        train_err_evt,
  input wire logic        train_done_evt,
  input wire logic        ovr_load,
  input wire logic        retrain_req,
  input wire logic        spl_msg_req,
  input wire logic [7:0]  spl_value,
  input wire logic [1:0]  spl_scale
);
  logic            load_d;
  // Load strobe as the register bank sees it, one cycle late
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      load_d <= 1'b0;
    else
      load_d <= ovr_load;
  end
  wire logic       caps_wr = cfg_wr && cfg_addr == 12'h00d4;
  wire logic       pwr_wr  = caps_wr && (|cfg_be[2:0]) && !load_d;
  wire logic       link_rd = cfg_rd && cfg_addr == 12'h00d0;
  wire logic       rt_wr   = cfg_wr && cfg_addr == 12'h00d0 && cfg_be[0]
                             && cfg_wdata[5];
  wire logic [9:0] pwr_fld = cfg_wdata[16:7];
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  a_pwr_msg: assert property (pwr_wr |=> spl_msg_req)
    else $error("power limit message missing");
  a_msg_cause: assert property (spl_msg_req |-> $past(pwr_wr))
    else $error("power limit message without write");
  a_pwr_load: assert property (
    caps_wr && cfg_be == 4'hf && !load_d
    |=> {spl_scale, spl_value} == $past(pwr_fld))
    else $error("power fields not loaded");
  a_pwr_hold: assert property (
    !caps_wr && !ovr_load && !$past(ovr_load)
    |=> $stable(spl_value) && $stable(spl_scale))
    else $error("power fields changed");
  a_rt_req: assert property (rt_wr |=> retrain_req)
    else $error("retrain request missing");
  a_rt_zero: assert property (link_rd |=> !cfg_rdata[5])
    else $error("retrain bit reads one");
  a_unmapped_zero: assert property (
    cfg_rd && cfg_addr != 12'h00d0 && cfg_addr != 12'h00d4
    |=> cfg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_err_set: assert property (
    train_err_evt ##1 !train_done_evt ##1 link_rd |=> cfg_rdata[26])
    else $error("training error not set");
  c_msg: cover property (spl_msg_req);
  c_retrain: cover property (retrain_req);
  c_load: cover property (ovr_load);
endmodule
bind lsc_regs lsc_regs_chk i_chk (.clock(clock), .rst_n(rst_n),
  .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
  .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
  .train_err_evt(train_err_evt), .train_done_evt(train_done_evt),
  .ovr_load(ovr_load), .retrain_req(retrain_req),
  .spl_msg_req(spl_msg_req), .spl_value(spl_value), .spl_scale(spl_scale));
`default_nettype wire

// *** sim/lsc_regs_bench.sv ***
// Bench: register accesses and link events on the register block
// Assumes a downstream-port instance on a 40 MHz clock
`timescale 1ns/100ps
`default_nettype none
module lsc_regs_bench;
  logic        clock, rst_n, cfg_wr, cfg_rd, dl_active, ovr_slot_clk;
  logic        ovr_load, train_err_evt, train_done_evt;
  logic        retrain_req, spl_msg_req;
  logic [11:0] cfg_addr;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, ovr_caps;
  logic [7:0]  spl_value, msg_count;
  logic [1:0]  spl_scale;
  logic [9:0]  payload;
  int          bad_count = 0;
  int          tests_run = 0;
  lsc_regs i_dut (.clock(clock), .rst_n(rst_n), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .train_err_evt(train_err_evt), .train_done_evt(train_done_evt),
    .dl_active(dl_active), .ovr_load(ovr_load), .ovr_caps(ovr_caps),
    .ovr_slot_clk(ovr_slot_clk), .retrain_req(retrain_req),
    .spl_msg_req(spl_msg_req), .spl_value(spl_value), .spl_scale(spl_scale));
  lsc_link_partner i_lp (.clock(clock), .rst_n(rst_n),
    .msg_req(spl_msg_req), .msg_value(spl_value), .msg_scale(spl_scale),
    .msg_count_reg(msg_count), .payload_reg(payload));
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [3:0] b,
                    input logic [31:0] d);
    @(posedge clock);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_be <= b;
    cfg_wdata <= d;
    @(posedge clock);
    cfg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, e);
    @(posedge clock);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge clock);
    cfg_rd <= 1'b0;
    #1 chk("cfg_rdata", e, cfg_rdata & m);
  endtask
  // One-cycle pulse on load, done or error
  task automatic pulse(input logic [2:0] k);
    @(posedge clock);
    {ovr_load, train_done_evt, train_err_evt} <= k;
    @(posedge clock);
    {ovr_load, train_done_evt, train_err_evt} <= 3'h0;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Roughly 43 cycles of tests, generous margin
  initial
  begin
    repeat (1000) @(posedge clock);
    bad_count++;
    final_report;
  end
  initial
  begin
    {rst_n, cfg_wr, cfg_rd, dl_active, ovr_slot_clk} = 5'h00;
    {ovr_load, train_err_evt, train_done_evt} = 3'h0;
    {cfg_addr, cfg_be, cfg_wdata, ovr_caps} = 80'h0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    rd(12'h00d0, 32'h3c00_0020, 32'h1800_0000);
    rd(12'h00d4, 32'hffff_ffff, 32'h0000_0cdf);
    $display("test reset done");
    wr(12'h00d4, 4'hf, 32'hffff_ffff);
    rd(12'h00d4, 32'hffff_ffff, 32'h0001_ffdf);
    chk("partner", 32'h0003_ff01, {14'h0000, payload, msg_count});
    wr(12'h00d4, 4'h4, 32'h0000_0000);
    rd(12'h00d4, 32'hffff_ffff, 32'h0000_ffdf);
    chk("partner", 32'h0001_ff02, {14'h0000, payload, msg_count});
    $display("test power limit done");
    pulse(3'h1);
    rd(12'h00d0, 32'h0400_0000, 32'h0400_0000);
    @(posedge clock);
    dl_active <= 1'b1;
    pulse(3'h2);
    rd(12'h00d0, 32'h3c00_0020, 32'h3000_0000);
    wr(12'h00d0, 4'h1, 32'h0000_0020);
    #1 chk("retrain_req", 32'h0000_0001, {31'h0000_0000, retrain_req});
    rd(12'h00d0, 32'h3c00_0020, 32'h3800_0000);
    $display("test link status done");
    wr(12'h00d8, 4'hf, 32'hffff_ffff);
    rd(12'h00d8, 32'hffff_ffff, 32'h0000_0000);
    rd(12'h00d4, 32'hffff_ffff, 32'h0000_ffdf);
    $display("test unmapped done");
    @(posedge clock);
    ovr_caps <= 32'haaaf_212a;
    pulse(3'h4);
    rd(12'h00d4, 32'hffff_ffff, 32'haaa9_212a);
    rd(12'h00d0, 32'h1000_0000, 32'h0000_0000);
    chk("partner", 32'h0001_ff02, {14'h0000, payload, msg_count});
    $display("test override done");
    final_report;
  end
endmodule
`default_nettype wire
